/* rtl/uart_ctrl_pkg.sv */
// uart_ctrl_pkg: shared constants and types of the serial port block
// assumes one clock domain and a 32-bit AXI4-Lite register bus
//
// Overview of operation
// - two-bit field picks shift mode, 8-bit UART or two 9-bit UARTs
// - modes 2/3 with multiprocessor enable: no receive flag if ninth bit 0
// - mode 1 with multiprocessor enable: receive flag only on valid stop
// - reception runs only while the receiver enable bit is set
// - modes 2/3 send the transmit ninth bit as ninth data bit
// - modes 2/3 store the received ninth data bit in receive ninth bit
// - mode 1 without multiprocessor enable stores stop bit; mode 0 unused
// - transmit flag set after 8th bit in mode 0, else at stop start
// - hardware never clears the transmit flag; software writes it
// - receive flag set after 8th bit in mode 0, else mid stop bit
// - hardware never clears the receive flag; software writes it
// - buffer write starts transmission; buffer read gives receive register
// - mode 0 receives when flag clear and enabled; else on start bit

package uart_ctrl_pkg;

  // operating mode codes as held in the two mode select bits
  typedef enum logic [1:0]
  {
    MODE_SHIFT       = 2'h0,
    MODE_UART8       = 2'h1,
    MODE_UART9_FIXED = 2'h2,
    MODE_UART9_VAR   = 2'h3
  } mode_t;

  // control and status register, bit 7 first
  typedef struct packed
  {
    logic mode_select_high;
    logic mode_select_low;
    logic multiprocessor_enable;
    logic receiver_enable;
    logic transmit_ninth_bit;
    logic receive_ninth_bit;
    logic transmit_complete_flag;
    logic receive_complete_flag;
  } ctrl_t;

  // received frame: bit8 is stop (mode 1) or ninth bit (modes 2/3)
  typedef struct packed
  {
    logic       bit9;
    logic       bit8;
    logic [7:0] data;
  } rx_frame_t;

  // register indices; byte address is four times the index
  localparam int          ADDR_W             = 12;
  localparam logic [9:0]  IDX_CONTROL_STATUS = 10'h098;
  localparam logic [9:0]  IDX_BUFFER         = 10'h099;
  localparam logic [9:0]  IDX_IRQ_STATUS     = 10'h0a0;
  localparam logic [9:0]  IDX_IRQ_ENABLE     = 10'h0a1;
  localparam logic [9:0]  IDX_IRQ_CLEAR      = 10'h0a2;

  // reset values and interrupt bit layout
  localparam ctrl_t       CTRL_RESET   = 8'h00;
  localparam int          IRQ_W        = 2;
  localparam int          IRQ_TX_BIT   = 0;
  localparam int          IRQ_RX_BIT   = 1;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // clock cycles per bit time, defaults for each rate class
  localparam logic [15:0] DEF_MODE0_CYCLES = 16'h000c;
  localparam logic [15:0] DEF_MODE2_CYCLES = 16'h0040;
  localparam logic [15:0] DEF_ASYNC_CYCLES = 16'h0440;

  // index of the last bit of a frame, transmit and receive
  localparam logic [3:0]  TX_LAST_SHIFT = 4'h7;
  localparam logic [3:0]  TX_LAST_UART8 = 4'h9;
  localparam logic [3:0]  TX_LAST_UART9 = 4'ha;
  localparam logic [3:0]  RX_LAST_SHIFT = 4'h7;
  localparam logic [3:0]  RX_LAST_UART8 = 4'h8;
  localparam logic [3:0]  RX_LAST_UART9 = 4'h9;

endpackage

/* rtl/bit_sync.sv */
// bit_sync: two-stage synchroniser for one level from a pin
// assumes the level idles high, as a serial line does
`timescale 1ns/10ps
`default_nettype none

module bit_sync
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // level in and synchronised level out
  input  wire logic d,
  output logic      q
);
  import uart_ctrl_pkg::*;

  logic meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= 1'b1;
      q      <= 1'b1;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

`default_nettype wire

/* rtl/serial_tx.sv */
// serial_tx: sends one frame per start pulse in the selected mode
// assumes start only while idle and a bit time of two cycles or more
`timescale 1ns/10ps
`default_nettype none

module serial_tx
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // frame request
  input  wire logic                 start,
  input  wire uart_ctrl_pkg::mode_t mode,
  input  wire logic [7:0]           data,
  input  wire logic                 ninth,
  input  wire logic [15:0]          bit_cycles,
  // line side
  output logic                      busy,
  output logic                      ser_out,
  output logic                      shift_clk,
  output logic                      done
);
  import uart_ctrl_pkg::*;

  logic [15:0] cnt_q;
  logic [3:0]  idx_q;
  logic [10:0] frame_q;
  mode_t       mode_q;
  logic [3:0]  last;
  logic        bit_end;

  // index of the final bit of the frame in flight
  always_comb
  begin
    unique case (mode_q)
      MODE_SHIFT:       last = TX_LAST_SHIFT;
      MODE_UART8:       last = TX_LAST_UART8;
      MODE_UART9_FIXED: last = TX_LAST_UART9;
      MODE_UART9_VAR:   last = TX_LAST_UART9;
    endcase
  end

  // bit timing, frame load and shifting
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy    <= 1'b0;
      cnt_q   <= 16'h0000;
      idx_q   <= 4'h0;
      frame_q <= 11'h7ff;
      mode_q  <= MODE_SHIFT;
    end
    else if (!busy)
    begin
      if (start)
      begin
        busy   <= 1'b1;
        cnt_q  <= 16'h0000;
        idx_q  <= 4'h0;
        mode_q <= mode;
        unique case (mode)
          MODE_SHIFT:       frame_q <= {3'h7, data};
          MODE_UART8:       frame_q <= {2'h3, data, 1'b0};
          MODE_UART9_FIXED: frame_q <= {1'b1, ninth, data, 1'b0};
          MODE_UART9_VAR:   frame_q <= {1'b1, ninth, data, 1'b0};
        endcase
      end
    end
    else if (bit_end)
    begin
      cnt_q <= 16'h0000;
      if (idx_q == last)
        busy <= 1'b0;
      else
        idx_q <= idx_q + 4'h1;
    end
    else
      cnt_q <= cnt_q + 16'h0001;
  end

  // line value, shift clock (low in first half) and completion pulse
  assign bit_end   = busy && (cnt_q == bit_cycles - 16'h0001);
  assign ser_out   = busy ? frame_q[idx_q] : 1'b1;
  assign shift_clk = !(busy && (mode_q == MODE_SHIFT)
                     && (cnt_q < {1'b0, bit_cycles[15:1]}));
  assign done      = bit_end && ((mode_q == MODE_SHIFT) ? (idx_q == last)
                     : (idx_q == last - 4'h1));

endmodule

`default_nettype wire

/* rtl/serial_port_control_status.sv */
// serial_port_control_status: serial port registers, flags and receiver
// assumes a single AXI4-Lite master and one clock for bus and line
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module serial_port_control_status
#(
  parameter logic [15:0] MODE0_CYCLES = uart_ctrl_pkg::DEF_MODE0_CYCLES,
  parameter logic [15:0] MODE2_CYCLES = uart_ctrl_pkg::DEF_MODE2_CYCLES,
  parameter logic [15:0] ASYNC_CYCLES = uart_ctrl_pkg::DEF_ASYNC_CYCLES
)
(
  // clock and reset
  input  wire logic                             REF_CLK,
  input  wire logic                             RST,
  // axi4-lite write address and data
  input  wire logic [uart_ctrl_pkg::ADDR_W-1:0] AWADDR,
  input  wire logic                             AWVALID,
  output logic                                  AWREADY,
  input  wire logic [31:0]                      WDATA,
  input  wire logic [3:0]                       WSTRB,
  input  wire logic                             WVALID,
  output logic                                  WREADY,
  // axi4-lite write response
  output logic [1:0]                            BRESP,
  output logic                                  BVALID,
  input  wire logic                             BREADY,
  // axi4-lite read
  input  wire logic [uart_ctrl_pkg::ADDR_W-1:0] ARADDR,
  input  wire logic                             ARVALID,
  output logic                                  ARREADY,
  output logic [31:0]                           RDATA,
  output logic [1:0]                            RRESP,
  output logic                                  RVALID,
  input  wire logic                             RREADY,
  // serial pins
  output logic                                  TXD,
  input  wire logic                             RXD_I,
  output logic                                  RXD_O,
  output logic                                  RXD_OE,
  // interrupt
  output logic                                  IRQ
);
  import uart_ctrl_pkg::*;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_t;

  // ************************************************************
  // declarations
  // ************************************************************
  ctrl_t              ctrl_q;
  mode_t              mode;
  logic [7:0]         rx_buf_q;
  logic [IRQ_W-1:0]   irq_status_q;
  logic [IRQ_W-1:0]   irq_enable_q;
  logic [IRQ_W-1:0]   irq_events;
  logic [IRQ_W-1:0]   irq_clear;
  logic [15:0]        bit_cycles;
  logic               rxd_s;
  logic               aw_have_q;
  logic               w_have_q;
  logic [9:0]         wr_idx_q;
  logic [31:0]        wr_data_q;
  logic [3:0]         wr_strb_q;
  logic               aw_take;
  logic               w_take;
  logic               wr_go;
  logic               wr_en;
  logic               wr_ok;
  logic               ar_take;
  logic [9:0]         rd_idx;
  logic [31:0]        rd_data;
  logic               rd_ok;
  logic               tx_start;
  logic               tx_busy;
  logic               tx_ser;
  logic               tx_sclk;
  logic               tx_done;
  rx_state_t          rx_state_q;
  logic [15:0]        rx_cnt_q;
  logic [3:0]         rx_idx_q;
  logic [9:0]         rx_sh_q;
  logic               rx_prev_q;
  logic               rx_done_q;
  logic [3:0]         rx_last;
  logic               rx_tick;
  logic               rx_half;
  logic               rx_go0;
  logic               rx_sclk;
  logic               rx_accept;
  rx_frame_t          rx_frame;

  // mode from the two select bits
  assign mode = mode_t'({ctrl_q.mode_select_high,
                         ctrl_q.mode_select_low});

  // bit time per mode: shift, fixed 9-bit, variable rate
  always_comb
  begin
    unique case (mode)
      MODE_SHIFT:       bit_cycles = MODE0_CYCLES;
      MODE_UART8:       bit_cycles = ASYNC_CYCLES;
      MODE_UART9_FIXED: bit_cycles = MODE2_CYCLES;
      MODE_UART9_VAR:   bit_cycles = ASYNC_CYCLES;
    endcase
  end

  // ************************************************************
  // pin input synchroniser
  // ************************************************************
  bit_sync u_rxd_sync
  (
    .clk (REF_CLK),
    .rst (RST),
    .d   (RXD_I),
    .q   (rxd_s)
  );

  // ************************************************************
  // axi4-lite write channel
  // ************************************************************
  assign aw_take = AWVALID && AWREADY;
  assign w_take  = WVALID && WREADY;
  assign wr_go   = aw_have_q && w_have_q && !BVALID;
  assign wr_en   = wr_go && wr_strb_q[0];

  // address and data are held until both have arrived
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      wr_idx_q  <= 10'h000;
      wr_data_q <= 32'h0000_0000;
      wr_strb_q <= 4'h0;
    end
    else
    begin
      if (aw_take)
        wr_idx_q <= AWADDR[ADDR_W-1:2];
      if (w_take)
      begin
        wr_data_q <= WDATA;
        wr_strb_q <= WSTRB;
      end
    end
  end

  // handshake flags and response
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      AWREADY   <= 1'b0;
      WREADY    <= 1'b0;
      BVALID    <= 1'b0;
      BRESP     <= RESP_OKAY;
    end
    else
    begin
      aw_have_q <= !wr_go && (aw_have_q || aw_take);
      w_have_q  <= !wr_go && (w_have_q || w_take);
      AWREADY   <= !aw_take && !aw_have_q && !wr_go && !BVALID;
      WREADY    <= !w_take && !w_have_q && !wr_go && !BVALID;
      if (wr_go)
      begin
        BVALID <= 1'b1;
        BRESP  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (BREADY)
        BVALID <= 1'b0;
    end
  end

  // writes to a mapped index are accepted
  assign wr_ok = (wr_idx_q == IDX_CONTROL_STATUS) ||
                 (wr_idx_q == IDX_BUFFER) ||
                 (wr_idx_q == IDX_IRQ_STATUS) ||
                 (wr_idx_q == IDX_IRQ_ENABLE) ||
                 (wr_idx_q == IDX_IRQ_CLEAR);

  // ************************************************************
  // axi4-lite read channel
  // ************************************************************
  assign ar_take = ARVALID && ARREADY;
  assign rd_idx  = ARADDR[ADDR_W-1:2];

  // read mux; clear register reads as zero
  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    unique case (rd_idx)
      IDX_CONTROL_STATUS: rd_data[7:0]       = ctrl_q;
      IDX_BUFFER:         rd_data[7:0]       = rx_buf_q;
      IDX_IRQ_STATUS:     rd_data[IRQ_W-1:0] = irq_status_q;
      IDX_IRQ_ENABLE:     rd_data[IRQ_W-1:0] = irq_enable_q;
      IDX_IRQ_CLEAR:      rd_data            = 32'h0000_0000;
      default:            rd_ok              = 1'b0;
    endcase
  end

  // read answer follows the address by one cycle
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h0000_0000;
      RRESP   <= RESP_OKAY;
    end
    else
    begin
      ARREADY <= !ar_take && !RVALID;
      if (ar_take)
      begin
        RVALID <= 1'b1;
        RDATA  <= rd_data;
        RRESP  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (RREADY)
        RVALID <= 1'b0;
    end
  end

  // ************************************************************
  // control register and receive buffer
  // ************************************************************
  // hardware sets after the software write, so a set is never lost
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      ctrl_q <= CTRL_RESET;
    else
    begin
      if (wr_en && (wr_idx_q == IDX_CONTROL_STATUS))
        ctrl_q <= ctrl_t'(wr_data_q[7:0]);
      if (tx_done)
        ctrl_q.transmit_complete_flag <= 1'b1;
      if (rx_accept)
      begin
        ctrl_q.receive_complete_flag <= 1'b1;
        if (mode != MODE_SHIFT)
          ctrl_q.receive_ninth_bit <= rx_frame.bit8;
      end
    end
  end

  // receive register, separate from the transmit side
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      rx_buf_q <= 8'h00;
    else if (rx_accept)
      rx_buf_q <= rx_frame.data;
  end

  // ************************************************************
  // transmitter
  // ************************************************************
  // a buffer write while a frame is in flight is dropped
  assign tx_start = wr_en && (wr_idx_q == IDX_BUFFER) && !tx_busy;

  serial_tx u_tx
  (
    .clk        (REF_CLK),
    .rst        (RST),
    .start      (tx_start),
    .mode       (mode),
    .data       (wr_data_q[7:0]),
    .ninth      (ctrl_q.transmit_ninth_bit),
    .bit_cycles (bit_cycles),
    .busy       (tx_busy),
    .ser_out    (tx_ser),
    .shift_clk  (tx_sclk),
    .done       (tx_done)
  );

  // ************************************************************
  // receiver
  // ************************************************************
  // last sampled bit index per mode
  always_comb
  begin
    unique case (mode)
      MODE_SHIFT:       rx_last = RX_LAST_SHIFT;
      MODE_UART8:       rx_last = RX_LAST_UART8;
      MODE_UART9_FIXED: rx_last = RX_LAST_UART9;
      MODE_UART9_VAR:   rx_last = RX_LAST_UART9;
    endcase
  end

  assign rx_tick  = rx_cnt_q == bit_cycles - 16'h0001;
  assign rx_half  = rx_cnt_q == {1'b0, bit_cycles[15:1]} - 16'h0001;
  assign rx_go0   = ctrl_q.receiver_enable && !tx_busy && !rx_done_q
                    && !ctrl_q.receive_complete_flag;
  assign rx_sclk  = !((rx_state_q == RX_BITS) && (mode == MODE_SHIFT)
                    && (rx_cnt_q < {1'b0, bit_cycles[15:1]}));
  assign rx_frame = rx_frame_t'(rx_sh_q);

  // start detect, mid-bit sampling (end of bit in shift mode)
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      rx_state_q <= RX_IDLE;
      rx_cnt_q   <= 16'h0000;
      rx_idx_q   <= 4'h0;
      rx_sh_q    <= 10'h000;
      rx_prev_q  <= 1'b1;
      rx_done_q  <= 1'b0;
    end
    else
    begin
      rx_prev_q <= rxd_s;
      rx_done_q <= 1'b0;
      unique case (rx_state_q)
        RX_IDLE:
        begin
          rx_cnt_q <= 16'h0000;
          rx_idx_q <= 4'h0;
          if (mode == MODE_SHIFT)
          begin
            if (rx_go0)
              rx_state_q <= RX_BITS;
          end
          else if (ctrl_q.receiver_enable && rx_prev_q && !rxd_s)
            rx_state_q <= RX_START;
        end
        RX_START:
        begin
          if (!ctrl_q.receiver_enable)
            rx_state_q <= RX_IDLE;
          else if (rx_half)
          begin
            rx_cnt_q   <= 16'h0000;
            rx_state_q <= rxd_s ? RX_IDLE : RX_BITS;
          end
          else
            rx_cnt_q <= rx_cnt_q + 16'h0001;
        end
        RX_BITS:
        begin
          if (!ctrl_q.receiver_enable)
            rx_state_q <= RX_IDLE;
          else if (rx_tick)
          begin
            rx_cnt_q          <= 16'h0000;
            rx_sh_q[rx_idx_q] <= rxd_s;
            if (rx_idx_q == rx_last)
            begin
              rx_done_q  <= 1'b1;
              rx_state_q <= RX_IDLE;
            end
            else
              rx_idx_q <= rx_idx_q + 4'h1;
          end
          else
            rx_cnt_q <= rx_cnt_q + 16'h0001;
        end
      endcase
    end
  end

  // multiprocessor gating: bit8 is the stop bit in mode 1, else ninth
  assign rx_accept = rx_done_q && ((mode == MODE_SHIFT)
                     || !ctrl_q.multiprocessor_enable
                     || rx_frame.bit8);

  // ************************************************************
  // interrupt status, enable and clear
  // ************************************************************
  assign irq_events[IRQ_TX_BIT] = tx_done;
  assign irq_events[IRQ_RX_BIT] = rx_accept;
  assign irq_clear = (wr_en && (wr_idx_q == IDX_IRQ_CLEAR))
                     ? wr_data_q[IRQ_W-1:0] : {IRQ_W{1'b0}};

  // sticky status, set wins over clear; level interrupt
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      irq_status_q <= {IRQ_W{1'b0}};
      irq_enable_q <= {IRQ_W{1'b0}};
      IRQ          <= 1'b0;
    end
    else
    begin
      irq_status_q <= (irq_status_q & ~irq_clear) | irq_events;
      if (wr_en && (wr_idx_q == IDX_IRQ_ENABLE))
        irq_enable_q <= wr_data_q[IRQ_W-1:0];
      IRQ <= |(irq_status_q & irq_enable_q);
    end
  end

  // ************************************************************
  // pin drivers
  // ************************************************************
  // shift mode: clock on TXD, data driven on RXD while sending
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      TXD    <= 1'b1;
      RXD_O  <= 1'b1;
      RXD_OE <= 1'b0;
    end
    else
    begin
      TXD    <= (mode == MODE_SHIFT) ? (tx_sclk && rx_sclk) : tx_ser;
      RXD_OE <= tx_busy && (mode == MODE_SHIFT);
      RXD_O  <= (tx_busy && (mode == MODE_SHIFT)) ? tx_ser : 1'b1;
    end
  end

endmodule

`default_nettype wire

/* tb/serial_monitor.sv */
// serial_monitor: bus and interrupt timing checks on the port pins
// assumes it is bound into serial_port_control_status
`timescale 1ns/10ps
`default_nettype none
module serial_monitor
(
  // clock and reset
  input wire logic        REF_CLK,
  input wire logic        RST,
  // register bus
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic        RVALID,
  input wire logic        RREADY,
  // interrupt
  input wire logic        IRQ
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  // steps of a write: both channels taken, then the response taken
  sequence wr_take;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence b_take;
    BVALID && BREADY;
  endsequence
  // ****************
  // checks
  // ****************
  wr_answer_a: assert property (wr_take |=> !BVALID ##1 BVALID)
    else $error("write answer late");
  ready_back_a: assert property (b_take |=> !AWREADY ##1 AWREADY)
    else $error("write ready not back");
  aw_held_a: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken during response");
  b_stands_a: assert property (BVALID && !BREADY |=>
    BVALID && $stable(BRESP)) else $error("response dropped");
  rd_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read answer late");
  r_stands_a: assert property (RVALID && !RREADY |=>
    RVALID && $stable(RDATA)) else $error("read data dropped");
  ar_held_a: assert property (RVALID |-> !ARREADY)
    else $error("read taken during answer");
  irq_fall_a: assert property ($fell(IRQ) |-> $past(BVALID))
    else $error("interrupt dropped without a write");
endmodule
bind serial_port_control_status serial_monitor serial_monitor_i
(
  .REF_CLK(REF_CLK), .RST(RST), .AWVALID(AWVALID), .AWREADY(AWREADY),
  .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
  .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
  .RVALID(RVALID), .RREADY(RREADY), .IRQ(IRQ)
);
`default_nettype wire

/* tb/line_peer.sv */
// line_peer: remote transceiver sending frames on the receive line
// assumes go is a one-cycle pulse and frames do not overlap
`timescale 1ns/10ps
`default_nettype none
module line_peer
#(
  parameter int BIT_CYCLES = 8
)
(
  // clock
  input  wire logic        clk,
  // frame, lsb first, and its bit count
  input  wire logic        go,
  input  wire logic [10:0] frame,
  input  wire logic [3:0]  len,
  // serial line, idles high like a pulled-up wire
  output logic             line
);
  initial line = 1'b1;
  // shift the frame out, then release the line to idle
  always @(posedge clk)
    if (go)
    begin
      for (int i = 0; i < len; i++)
      begin
        line <= frame[i];
        repeat (BIT_CYCLES) @(posedge clk);
      end
      line <= 1'b1;
    end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// testbench: register, transmit and receive tests of the serial port
// assumes package, design, peer and monitor are compiled first
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import uart_ctrl_pkg::*;
  logic clk = 0, rst = 1, awv = 0, wv = 0, brd = 0, arv = 0, rrd = 0;
  logic go = 0, awr, wrdy, bv, arr, rv, txd, rxd, rxo, oe, irq, acc;
  logic [11:0] aw = 0, ar = 0;
  logic [31:0] wd = 0, rd, v;
  logic [1:0] br, rr;
  logic [10:0] frame = 0;
  logic [7:0] ex;
  logic [3:0] len = 0;
  int seed = 32'hfd1f_1581, err_total = 0, n_checks = 0, cyc = 0;
  int rxbuf = 0, m, k;
  // ****************
  // clock, timeout, parts
  // ****************
  always #4 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      report_and_stop;
    end
  end
  serial_port_control_status #(.MODE0_CYCLES(16'h0004),
    .MODE2_CYCLES(16'h0008), .ASYNC_CYCLES(16'h0008))
  serial_port_control_status_i
  (
    .REF_CLK(clk), .RST(rst), .AWADDR(aw), .AWVALID(awv), .AWREADY(awr),
    .WDATA(wd), .WSTRB(4'hf), .WVALID(wv), .WREADY(wrdy), .BRESP(br),
    .BVALID(bv), .BREADY(brd), .ARADDR(ar), .ARVALID(arv),
    .ARREADY(arr), .RDATA(rd), .RRESP(rr), .RVALID(rv), .RREADY(rrd),
    .TXD(txd), .RXD_I(rxd), .RXD_O(rxo), .RXD_OE(oe), .IRQ(irq)
  );
  line_peer #(.BIT_CYCLES(8)) line_peer_i
  (.clk(clk), .go(go), .frame(frame), .len(len), .line(rxd));
  // compare one result
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bus write, response ready after a random stall
  task automatic wrc(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] e);
    logic ad, dd;
    ad = 0;
    dd = 0;
    aw <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    while (!(ad && dd))
    begin
      @(posedge clk);
      ad = ad | awr;
      dd = dd | wrdy;
      awv <= !ad;
      wv <= !dd;
    end
    repeat ($random(seed) & 1) @(posedge clk);
    brd <= 1;
    do
      @(posedge clk);
    while (!bv);
    brd <= 0;
    chk("bresp", e, br);
  endtask
  // bus read and compare
  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                     input logic [1:0] r);
    ar <= a;
    arv <= 1;
    do
      @(posedge clk);
    while (!arr);
    arv <= 0;
    repeat ($random(seed) & 1) @(posedge clk);
    rrd <= 1;
    do
      @(posedge clk);
    while (!rv);
    rrd <= 0;
    chk("rdata", e, rd);
    chk("rresp", r, rr);
  endtask
  // sample a sent frame: data at shift clock rise, or bit middles
  task automatic tx_chk(input int md, input logic [8:0] d);
    logic [10:0] got, exf;
    got = '1;
    exf = md ? {1'b1, md == 1 || d[8], d[7:0], 1'b0} : {3'h7, d[7:0]};
    while (txd !== 1'b0) @(posedge clk);
    if (md == 0)
      for (int i = 0; i < 8; i++)
      begin
        while (txd !== 1'b1) @(posedge clk);
        got[i] = rxo;
        chk("drive", 1, oe);
        while (txd !== 1'b0 && i < 7) @(posedge clk);
      end
    else
    begin
      repeat (4) @(posedge clk);
      for (int i = 0; i < 11; i++)
      begin
        got[i] = txd;
        repeat (8) @(posedge clk);
      end
    end
    chk("frame", exf, got);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // main sequence: registers, every mode sending, receive gating table
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
    rdc(12'h260, 0, RESP_OKAY);
    rdc(12'h300, 0, RESP_SLVERR);
    wrc(12'h300, 1, RESP_SLVERR);
    v = $random(seed) & 32'h00ef;
    wrc(12'h260, v, RESP_OKAY);
    rdc(12'h260, v, RESP_OKAY);
    wrc(12'h284, 3, RESP_OKAY);
    $display("register tests done");
    for (m = 0; m < 4; m++)
    begin
      v = $random(seed);
      wrc(12'h260, {m[1:0], 2'h0, v[8], 3'h0}, RESP_OKAY);
      fork
        wrc(12'h264, v, RESP_OKAY);
        tx_chk(m, v[8:0]);
      join
      repeat (16) @(posedge clk);
      chk("drive", 0, oe);
      rdc(12'h260, {m[1:0], 2'h0, v[8], 3'h2}, RESP_OKAY);
      rdc(12'h280, 1, RESP_OKAY);
      chk("irq", 1, irq);
      wrc(12'h288, 3, RESP_OKAY);
      @(posedge clk);
      chk("irq", 0, irq);
      $display("transmit mode %0d done", m);
    end
    for (k = 0; k < 12; k++)
    begin
      v = $random(seed);
      m = 1 + k % 3;
      acc = k != 3 && (!v[9] || v[8]);
      wrc(12'h284, {k[0], 1'b0}, RESP_OKAY);
      wrc(12'h288, 3, RESP_OKAY);
      wrc(12'h260, {m[1:0], v[9], k != 3, 4'h0}, RESP_OKAY);
      frame <= {1'b1, v[8:0], 1'b0};
      len <= m == 1 ? 4'ha : 4'hb;
      go <= 1;
      @(posedge clk);
      go <= 0;
      repeat (110) @(posedge clk);
      if (acc)
        rxbuf = v[7:0];
      ex = {m[1:0], v[9], k != 3, 1'b0, acc & v[8], 1'b0, acc};
      rdc(12'h260, ex, RESP_OKAY);
      rdc(12'h264, rxbuf, RESP_OKAY);
      rdc(12'h280, {acc, 1'b0}, RESP_OKAY);
      chk("irq", acc & k[0], irq);
      $display("receive case %0d done", k);
    end
    wrc(12'h260, 8'h10, RESP_OKAY);
    repeat (60) @(posedge clk);
    rdc(12'h260, 8'h11, RESP_OKAY);
    rdc(12'h264, 8'hff, RESP_OKAY);
    chk("drive", 0, oe);
    $display("shift receive done");
    report_and_stop;
  end
endmodule
`default_nettype wire
